/* src/asr_regs.vh */
// register map, field positions, reset values and timing counts of the receiver
`ifndef ASR_REGS_VH
`define ASR_REGS_VH
// ==========================================================
// register byte offsets
`define ASR_OFF_BAUD_CONTROL   12'h000
`define ASR_OFF_RECEIVE_DATA   12'h004
`define ASR_OFF_RECV_STAT_CTRL 12'h008
`define ASR_OFF_BAUD_DIV_LOW   12'h00c
`define ASR_OFF_BAUD_DIV_HIGH  12'h010
`define ASR_OFF_XMIT_STAT_CTRL 12'h014
`define ASR_OFF_IRQ_CONTROL    12'h018
// ==========================================================
// receive status and control fields
`define ASR_RSC_PORT_EN   7
`define ASR_RSC_NINE_SEL  6
`define ASR_RSC_CONT_EN   4
`define ASR_RSC_ADDR_EN   3
`define ASR_RSC_FRAME_ERR 2
`define ASR_RSC_OVERRUN   1
`define ASR_RSC_NINTH     0
// baud control fields
`define ASR_BC_IDLE       6
`define ASR_BC_WIDE       3
// transmit status and control fields
`define ASR_TSC_SYNC      4
`define ASR_TSC_HIGH_SPD  2
`define ASR_TSC_EMPTY     1
// interrupt control fields
`define ASR_IC_GLOBAL     2
`define ASR_IC_PERIPH     1
`define ASR_IC_RECEIVE    0
// ==========================================================
// reset values
`define ASR_RST_RSC       8'h00
`define ASR_RST_BC        8'h00
`define ASR_RST_TSC       8'h02
`define ASR_RST_DIV       8'h00
// ==========================================================
// timing counts in oversample ticks
`define ASR_OVERSAMPLE    5'd16
`define ASR_HALF_BIT      5'd8
`define ASR_FULL_BIT      5'd16
`endif

/* src/asr_receiver.v */
// asynchronous serial receiver with apb register slave
`timescale 1ns/1ps
`include "asr_regs.vh"

// ==========================================================
// block overview
// the line is looked at on every baud tick; a falling edge opens a
// character, the start level is confirmed at mid-bit, each data bit is
// a two-of-three vote and the stop level becomes the framing status of
// its entry. finished characters wait in a two-entry fifo, and software
// reads the status word first, then pops the data word.
// not covered: transmitter, synchronous engine, auto-baud, wake-up.

module asr_receiver (
   // clock and reset
   input  wire        MCLK_I,
   input  wire        NRST_I,
   // apb slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output wire        PREADY_O,
   output wire        PSLVERR_O,
   // serial line
   input  wire        RECEIVE_PIN_I,
   // receive interrupt request
   output wire        RECEIVE_IRQ_O
);

   // ==========================================================
   // state codes
   // idle hunts for a falling edge, start confirms it at mid-bit, data
   // gathers the character, stop takes the stop level and pushes
   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_STOP  = 2'd3;

   // ==========================================================
   // registers
   reg  [7:0]  rsc;           // control bits of receive status/control
   reg  [7:0]  baud_control;
   reg  [7:0]  tsc;
   reg  [7:0]  baud_divisor_low;
   reg  [7:0]  baud_divisor_high;
   // the three request enables sit here so the request is built locally
   reg  [2:0]  irq_control;
   reg  [15:0] baud_count;
   reg  [1:0]  state;
   reg  [4:0]  tick_count;
   reg  [3:0]  bit_count;
   reg  [8:0]  receive_shift_reg;
   reg  [2:0]  samples;
   reg         line_prev;
   reg  [9:0]  fifo_mem [0:1]; // {frame error, ninth bit, data}
   reg         rd_ptr;
   reg         wr_ptr;
   reg  [1:0]  fifo_count;
   reg         overrun_error_flag;

   wire        serial_port_enable = rsc[`ASR_RSC_PORT_EN];
   wire        continuous_receive_enable = rsc[`ASR_RSC_CONT_EN];
   wire        nine_bit_receive_select = rsc[`ASR_RSC_NINE_SEL];
   wire        address_detect_enable = rsc[`ASR_RSC_ADDR_EN];
   wire        wide_baud_timer_select = baud_control[`ASR_BC_WIDE];
   wire        high_speed_baud_select = tsc[`ASR_TSC_HIGH_SPD];

   // receive runs only in async mode with both enables set; the sync
   // select has no engine behind it and only holds the receiver off.
   // dropping the port enable also empties the fifo, dropping only the
   // receive enable keeps what is stored
   wire rx_on = continuous_receive_enable & serial_port_enable &
                ~tsc[`ASR_TSC_SYNC];

   // ==========================================================
   // bus decode
   // one byte register per aligned word:
   //   0x000 baud control     0x004 receive data, a read pops it
   //   0x008 receive status   0x00c divisor low
   //   0x010 divisor high     0x014 transmit status and control
   //   0x018 request enables
   // any other word answers with an error and reads as zero
   function sel;
      input [11:0] addr;
      input [11:0] off;
      begin
         sel = (addr == off);
      end
   endfunction

   wire bus_wr = PSEL_I & PENABLE_I & PWRITE_I;
   wire bus_rd = PSEL_I & PENABLE_I & ~PWRITE_I;
   wire known  = sel(PADDR_I, `ASR_OFF_BAUD_CONTROL) |
                 sel(PADDR_I, `ASR_OFF_RECEIVE_DATA) |
                 sel(PADDR_I, `ASR_OFF_RECV_STAT_CTRL) |
                 sel(PADDR_I, `ASR_OFF_BAUD_DIV_LOW) |
                 sel(PADDR_I, `ASR_OFF_BAUD_DIV_HIGH) |
                 sel(PADDR_I, `ASR_OFF_XMIT_STAT_CTRL) |
                 sel(PADDR_I, `ASR_OFF_IRQ_CONTROL);
   // both responses are combinational; the error one only counts in the
   // access phase, where the master samples it
   assign PREADY_O  = 1'b1;            // every access finishes at once
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~known;
   wire div_wr = bus_wr & (sel(PADDR_I, `ASR_OFF_BAUD_DIV_LOW) |
                           sel(PADDR_I, `ASR_OFF_BAUD_DIV_HIGH));
   wire data_rd = bus_rd & sel(PADDR_I, `ASR_OFF_RECEIVE_DATA);

   // ==========================================================
   // fifo head and flags
   // the pending flag is derived from the fill level, so software has
   // nothing to set or clear; an empty fifo shows clean status because
   // the stored bits only mean something for a real entry
   wire [9:0] head = fifo_mem[rd_ptr];
   wire       fifo_empty = (fifo_count == 2'd0);
   wire       receive_pending_flag = rx_on & ~fifo_empty;
   // framing status never raises the request by itself
   assign RECEIVE_IRQ_O = receive_pending_flag &
                          irq_control[`ASR_IC_RECEIVE] &
                          irq_control[`ASR_IC_PERIPH] &
                          irq_control[`ASR_IC_GLOBAL];
   wire framing_error_flag = ~fifo_empty & head[9];
   wire received_ninth_bit = ~fifo_empty & head[8];
   wire receiver_idle_flag = (state == ST_IDLE);

   // ==========================================================
   // read mux; reserved bits read zero except bit 5 of receive status, which reads back as written. data is taken at the setup edge
   // so it already stands through the access phase
   always @(posedge MCLK_I) begin
      if (!NRST_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
         PRDATA_O <= 32'h0000_0000;
         case (PADDR_I)
            `ASR_OFF_BAUD_CONTROL: begin
               PRDATA_O[7:0] <= {1'b0, receiver_idle_flag, 2'b00,
                                 wide_baud_timer_select, 3'b000};
            end
            `ASR_OFF_RECEIVE_DATA: begin
               // an empty fifo reads zero, not a stale or unwritten entry
               PRDATA_O[7:0] <= fifo_empty ? 8'h00 : head[7:0];
            end
            `ASR_OFF_RECV_STAT_CTRL: begin
               PRDATA_O[7:0] <= {rsc[7:3], framing_error_flag,
                                 overrun_error_flag, received_ninth_bit};
            end
            `ASR_OFF_BAUD_DIV_LOW: begin
               PRDATA_O[7:0] <= baud_divisor_low;
            end
            `ASR_OFF_BAUD_DIV_HIGH: begin
               PRDATA_O[7:0] <= baud_divisor_high;
            end
            `ASR_OFF_XMIT_STAT_CTRL: begin
               PRDATA_O[7:0] <= tsc;
            end
            `ASR_OFF_IRQ_CONTROL: begin
               PRDATA_O[7:0] <= {5'b00000, irq_control};
            end
            default: begin
               PRDATA_O <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ==========================================================
   // register writes; status bits are hardware-owned. writes to the
   // data word or to an unmapped word fall to the default and change
   // nothing
   always @(posedge MCLK_I) begin
      if (!NRST_I) begin
         rsc               <= `ASR_RST_RSC;
         baud_control      <= `ASR_RST_BC;
         tsc               <= `ASR_RST_TSC;
         baud_divisor_low  <= `ASR_RST_DIV;
         baud_divisor_high <= `ASR_RST_DIV;
         irq_control       <= 3'b000;
      end else if (bus_wr) begin
         case (PADDR_I)
            `ASR_OFF_BAUD_CONTROL: begin
               baud_control <= {4'h0, PWDATA_I[`ASR_BC_WIDE], 3'b000};
            end
            `ASR_OFF_RECV_STAT_CTRL: begin
               rsc <= {PWDATA_I[7:3], 3'b000};
            end
            `ASR_OFF_BAUD_DIV_LOW: begin
               baud_divisor_low <= PWDATA_I[7:0];
            end
            `ASR_OFF_BAUD_DIV_HIGH: begin
               baud_divisor_high <= PWDATA_I[7:0];
            end
            `ASR_OFF_XMIT_STAT_CTRL: begin
               tsc <= {3'b000, PWDATA_I[`ASR_TSC_SYNC], 1'b0,
                       PWDATA_I[`ASR_TSC_HIGH_SPD], 2'b10};
            end
            `ASR_OFF_IRQ_CONTROL: begin
               irq_control <= PWDATA_I[2:0];
            end
            default: begin
               irq_control <= irq_control;
            end
         endcase
      end
   end

   // ==========================================================
   // baud timer: one tick per oversample; period = divisor + 1 clocks.
   // prescale ratios of the low-speed modes are folded into the divisor,
   // high_speed_baud_select is stored only, a known simplification.
   // a divisor write reloads the count from the divisor it replaces, so a
   // new rate applies only after one more old period; with both divisors at
   // zero a tick comes every clock, one bit per sixteen clocks
   wire [15:0] divisor = wide_baud_timer_select ?
                         {baud_divisor_high, baud_divisor_low} :
                         {8'h00, baud_divisor_low};
   wire        tick = (baud_count == 16'h0000);

   always @(posedge MCLK_I) begin
      if (!NRST_I) begin
         baud_count <= 16'h0000;
      end else if (div_wr | tick) begin
         baud_count <= divisor;
      end else begin
         baud_count <= baud_count - 16'h0001;
      end
   end

   // ==========================================================
   // bit recovery: three samples at ticks 6,7,8 of each bit. two of
   // three must agree, so one noisy sample near the centre cannot flip
   // the bit
   wire vote = (samples[0] & samples[1]) | (samples[1] & samples[2]) |
               (samples[0] & samples[2]);
   wire [3:0] last_bit = nine_bit_receive_select ? 4'd8 : 4'd7;
   // a new character is refused while overrun stands
   wire       push_char = tick & (state == ST_STOP) &
                          (tick_count == `ASR_FULL_BIT) & ~overrun_error_flag;
   // address detection only applies in nine-bit mode
   wire       keep_char = ~(nine_bit_receive_select & address_detect_enable &
                            ~receive_shift_reg[8]);
   wire       do_push = push_char & keep_char & (fifo_count != 2'd2);
   wire       do_pop  = data_rd & ~fifo_empty;
   // bits enter at the top, so an eight-bit character sits one place
   // high and is moved down before it is stored
   wire [8:0] aligned = nine_bit_receive_select ? receive_shift_reg :
                        {1'b0, receive_shift_reg[8:1]};

   // timing in ticks from the first low sample of the start bit: the
   // start level is rechecked at tick 8; each data bit is voted and
   // shifted 16 ticks after the previous one, one tick past its centre
   // so that the third sample is already in the history; the stop
   // level is taken 15 ticks after the last data bit. the sequencer
   // moves only on ticks, so the line is seen sixteen times per bit.
   // receiver sequencer; everything resets while disabled
   always @(posedge MCLK_I) begin
      if (!NRST_I || !rx_on) begin
         state             <= ST_IDLE;
         tick_count        <= 5'd0;
         bit_count         <= 4'd0;
         receive_shift_reg <= 9'h000;
         samples           <= 3'b111;
         line_prev         <= 1'b1;
      end else if (tick) begin
         line_prev <= RECEIVE_PIN_I;
         samples   <= {samples[1:0], RECEIVE_PIN_I};
         case (state)
            ST_IDLE: begin
               // restart the count here so the start check always
               // measures from the first low sample
               tick_count <= 5'd1;
               if (line_prev & ~RECEIVE_PIN_I) begin
                  state <= ST_START;
               end
            end
            ST_START: begin
               tick_count <= tick_count + 5'd1;
               if (tick_count == `ASR_HALF_BIT) begin
                  if (RECEIVE_PIN_I) begin
                     state <= ST_IDLE;
                  end else begin
                     tick_count <= 5'd1;
                     bit_count  <= 4'd0;
                     state      <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               tick_count <= tick_count + 5'd1;
               // bit centre plus one tick: third sample just taken
               if (tick_count == `ASR_FULL_BIT + 5'd1) begin
                  tick_count <= 5'd2;
                  // lsb first: new bits enter at the top
                  receive_shift_reg <= {vote, receive_shift_reg[8:1]};
                  bit_count <= bit_count + 4'd1;
                  if (bit_count == last_bit) begin
                     state <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               tick_count <= tick_count + 5'd1;
               // push_char fires on this same tick, so the entry lands
               // as the sequencer returns to idle
               if (tick_count == `ASR_FULL_BIT) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // two-entry fifo and overrun
   // one-bit pointers suffice for two entries; the count tells full from
   // empty when the pointers meet. a push and a pop on one clock leave
   // the count where it was
   wire [1:0] next_fifo_count = fifo_count + {1'b0, do_push} -
                                {1'b0, do_pop};
   always @(posedge MCLK_I) begin
      if (!NRST_I || !serial_port_enable) begin
         rd_ptr     <= 1'b0;
         wr_ptr     <= 1'b0;
         fifo_count <= 2'd0;
      end else begin
         if (do_push) begin
            // stop sampled as zero marks a framing error
            fifo_mem[wr_ptr] <= {~RECEIVE_PIN_I, aligned};
            wr_ptr <= ~wr_ptr;
         end
         if (do_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         fifo_count <= next_fifo_count;
      end
   end

   // the pop in the same cycle does not save the third character, and
   // a character dropped by address detection never counts toward it
   always @(posedge MCLK_I) begin
      if (!NRST_I || !rx_on) begin
         overrun_error_flag <= 1'b0;
      end else if (push_char & keep_char & (fifo_count == 2'd2)) begin
         overrun_error_flag <= 1'b1;
      end
   end

endmodule

/* dv/asr_line_model.sv */
// remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module asr_line_model #(
   parameter int BIT_CLKS = 16
) (
   // clock and line
   input  wire logic clk_i,
   output logic      line_o
);
   // ======================================================
   // frame driving
   // clocks per bit cell; the bench may change it between frames
   int bit_clks = BIT_CLKS;
   // line idles high between frames, like a released pull-up
   initial line_o = 1'b1;

   // one bit cell, changed only just after a clock edge
   task bit_out(input logic v);
      line_o <= v;
      repeat (bit_clks) @(posedge clk_i);
   endtask

   // start, data lsb first, stop, then one idle bit cell
   task send(input logic [8:0] d, input int nbits, input logic stop);
      @(posedge clk_i);
      bit_out(1'b0);
      for (int i = 0; i < nbits; i++)
         bit_out(d[i]);
      bit_out(stop);
      bit_out(1'b1);
   endtask

   // short low pulse that must not pass as a start bit
   task glitch(input int clks);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (clks) @(posedge clk_i);
      bit_out(1'b1);
      bit_out(1'b1);
   endtask
endmodule

/* dv/asr_receiver_chk.sv */
// port checker for the serial receiver
`timescale 1ns/1ps
module asr_chk (
   // clock and reset
   input wire logic        MCLK_I,
   input wire logic        NRST_I,
   // apb slave
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   // interrupt
   input wire logic        RECEIVE_IRQ_O
);
   // ======================================================
   // shadows of the enables, updated at the access edge
   logic [2:0] ic_sh;
   logic       port_sh;
   logic       cont_sh;
   logic       sync_sh;
   wire        acc = PSEL_I & PENABLE_I;
   wire        wr_at = acc & PWRITE_I;
   wire        map = (PADDR_I <= 12'h018) & (PADDR_I[1:0] == 2'h0);
   wire        rd8 = acc & !PWRITE_I & (PADDR_I == 12'h008);
   // only a data read or an enable write may lower the request
   wire        drop = (acc & !PWRITE_I & (PADDR_I == 12'h004))
                    | (wr_at & (PADDR_I == 12'h008))
                    | (wr_at & (PADDR_I == 12'h018))
                    | (wr_at & (PADDR_I == 12'h014));
   always @(posedge MCLK_I) begin
      if (!NRST_I) begin
         ic_sh <= 3'h0;
         port_sh <= 1'b0;
         cont_sh <= 1'b0;
         sync_sh <= 1'b0;
      end else if (wr_at & (PADDR_I == 12'h018)) begin
         ic_sh <= PWDATA_I[2:0];
      end else if (wr_at & (PADDR_I == 12'h008)) begin
         port_sh <= PWDATA_I[7];
         cont_sh <= PWDATA_I[4];
      end else if (wr_at & (PADDR_I == 12'h014)) begin
         sync_sh <= PWDATA_I[4];
      end
   end

   default clocking dc @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);

   // ======================================================
   // properties
   property p_irq_en; RECEIVE_IRQ_O |-> ic_sh == 3'h7; endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("irq without all enables");
   property p_irq_rx;
      RECEIVE_IRQ_O |-> port_sh & cont_sh & !sync_sh;
   endproperty
   a_irq_rx: assert property (p_irq_rx)
      else $error("irq while receiver off");
   property p_irq_fall;
      $fell(RECEIVE_IRQ_O) |-> $past(drop) || $past(drop, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("pending dropped with no cause");
   property p_frm_clr; rd8 & !port_sh |-> PRDATA_O[2:0] == 3'h0; endproperty
   a_frm_clr: assert property (p_frm_clr)
      else $error("status kept after port disable");
   property p_ovr_clr; rd8 & !cont_sh |-> !PRDATA_O[1]; endproperty
   a_ovr_clr: assert property (p_ovr_clr)
      else $error("overrun kept after receive disable");
   property p_ready; PSEL_I & !PENABLE_I |=> PREADY_O; endproperty
   a_ready: assert property (p_ready)
      else $error("no ready in access phase");
   property p_err; acc |-> PSLVERR_O == !map; endproperty
   a_err: assert property (p_err)
      else $error("error response wrong for address");
   property p_rd_top; acc & !PWRITE_I |-> PRDATA_O[31:8] == 24'h0; endproperty
   a_rd_top: assert property (p_rd_top)
      else $error("read data upper bits set");
   property p_gap_rd; acc & !PWRITE_I & !map |-> PRDATA_O == 32'h0; endproperty
   a_gap_rd: assert property (p_gap_rd)
      else $error("unmapped read returned data");

   c_irq: cover property ($rose(RECEIVE_IRQ_O));
   c_frm: cover property (rd8 & PRDATA_O[2]);
   c_ovr: cover property (rd8 & PRDATA_O[1]);
endmodule

/* dv/async_serial_receiver_bench.sv */
// register-level bench of the serial receiver
`timescale 1ns/1ps
`include "asr_regs.vh"
module async_serial_receiver_bench;
   localparam logic [11:0] o_bc = `ASR_OFF_BAUD_CONTROL,
      o_dat = `ASR_OFF_RECEIVE_DATA, o_rsc = `ASR_OFF_RECV_STAT_CTRL,
      o_dlo = `ASR_OFF_BAUD_DIV_LOW, o_dhi = `ASR_OFF_BAUD_DIV_HIGH,
      o_tsc = `ASR_OFF_XMIT_STAT_CTRL, o_ic = `ASR_OFF_IRQ_CONTROL;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         rx_line;
   wire         irq;
   int          bad_count = 0;
   int          comparisons = 0;

   always #50 mclk = ~mclk;

   asr_receiver dut_u (.MCLK_I(mclk), .NRST_I(nrst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .RECEIVE_PIN_I(rx_line), .RECEIVE_IRQ_O(irq));
   // divisor 0 gives one tick a clock, so a bit is 16 clocks
   asr_line_model #(.BIT_CLKS(16)) line_u (.clk_i(mclk), .line_o(rx_line));

   // ======================================================
   // report and compare
   task end_of_test;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      comparisons++;
      if (seen !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, seen);
      end
   endtask

   // ======================================================
   // apb master; a clock edge always passes between transfers
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("pready", {31'h0, pready}, 32'h1);
         end_of_test;
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(nm, r, {24'h0, e});
   endtask
   // the request is a level, so look at it once the edge has settled
   task irq_is(input logic e);
      @(negedge mclk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask

   // ======================================================
   // scenarios
   initial begin
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd("bc", o_bc, 8'h40);
      rd("rsc", o_rsc, 8'h00);
      rd("tsc", o_tsc, 8'h02);
      rd("gap", 12'h01c, 8'h00);
      wr(o_dhi, 8'h5a);
      rd("dhi", o_dhi, 8'h5a);
      wr(o_dhi, 8'h00);
      wr(o_dlo, 8'h00);
      $display("test registers done");
      // enables in the order software must use
      wr(o_ic, 8'h07);
      wr(o_rsc, 8'h90);
      line_u.send(9'h0a5, 8, 1'b1);
      irq_is(1'b1);
      wr(o_ic, 8'h03);
      irq_is(1'b0);
      wr(o_ic, 8'h07);
      rd("rsc", o_rsc, 8'h90);
      rd("dat", o_dat, 8'ha5);
      irq_is(1'b0);
      $display("test basic done");
      line_u.send(9'h03c, 8, 1'b0);
      line_u.send(9'h05a, 8, 1'b1);
      rd("rsc", o_rsc, 8'h94);
      rd("dat", o_dat, 8'h3c);
      rd("rsc", o_rsc, 8'h90);
      rd("dat", o_dat, 8'h5a);
      line_u.send(9'h0c3, 8, 1'b0);
      wr(o_rsc, 8'h80);
      rd("rsc", o_rsc, 8'h84);
      wr(o_rsc, 8'h00);
      rd("rsc", o_rsc, 8'h00);
      wr(o_rsc, 8'h90);
      irq_is(1'b0);
      $display("test framing done");
      line_u.send(9'h011, 8, 1'b1);
      line_u.send(9'h022, 8, 1'b1);
      line_u.send(9'h033, 8, 1'b1);
      rd("rsc", o_rsc, 8'h92);
      rd("dat", o_dat, 8'h11);
      rd("dat", o_dat, 8'h22);
      line_u.send(9'h044, 8, 1'b1);
      irq_is(1'b0);
      wr(o_rsc, 8'h80);
      rd("rsc", o_rsc, 8'h80);
      wr(o_rsc, 8'h90);
      $display("test overrun done");
      line_u.glitch(4);
      irq_is(1'b0);
      rd("bc", o_bc, 8'h40);
      fork
         line_u.send(9'h077, 8, 1'b1);
         begin
            repeat (40) @(posedge mclk);
            rd("bc", o_bc, 8'h00);
         end
      join
      rd("bc", o_bc, 8'h40);
      rd("dat", o_dat, 8'h77);
      $display("test start check done");
      wr(o_rsc, 8'hd8);
      line_u.send(9'h0ab, 9, 1'b1);
      irq_is(1'b0);
      line_u.send(9'h1c3, 9, 1'b1);
      rd("rsc", o_rsc, 8'hd9);
      rd("dat", o_dat, 8'hc3);
      wr(o_rsc, 8'hd0);
      line_u.send(9'h034, 9, 1'b1);
      rd("rsc", o_rsc, 8'hd0);
      rd("dat", o_dat, 8'h34);
      $display("test nine bit done");
      // tick every other clock; the high divisor only counts when wide
      wr(o_rsc, 8'h90);
      wr(o_dhi, 8'h5a);
      wr(o_dlo, 8'h01);
      line_u.bit_clks = 32;
      line_u.send(9'h096, 8, 1'b1);
      rd("dat", o_dat, 8'h96);
      wr(o_dhi, 8'h00);
      wr(o_bc, 8'h08);
      rd("bc", o_bc, 8'h48);
      line_u.send(9'h069, 8, 1'b1);
      rd("dat", o_dat, 8'h69);
      $display("test baud rate done");
      // synchronous select holds the receiver off
      wr(o_tsc, 8'h10);
      rd("tsc", o_tsc, 8'h12);
      line_u.send(9'h055, 8, 1'b1);
      wr(o_tsc, 8'h00);
      irq_is(1'b0);
      $display("test sync mode done");
      end_of_test;
   end
endmodule

bind asr_receiver asr_chk chk_u (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .RECEIVE_IRQ_O(RECEIVE_IRQ_O));
